// ---- logic/ccr_regs.sv ----
// card address register and card specific data record of a read-only card
// assumes a command decoder on ref_clk delivering checked frames as one-cycle pulses
// resetn is the card's own power-up detector output
//
// What this block does
// (RULE1) card address is 16 bits and defaults to 0x0001 when unassigned
// (RULE2) address 0x0000 is never assigned; select with 0x0000 sends card to standby
// (RULE3) address set by set-address command; addressed commands answer only on match
// (RULE4) address lost on power down; power-up reset reloads the default
// (RULE5) whole record is read only; don't care fields read as zero
// (RULE6) bits 127:126 carry structure version 1
// (RULE7) bits 125:122 carry protocol version 2
// (RULE8) async access-time byte is 0x08, unit low, multiplier middle, top zero
// (RULE9) clocked access byte 0x03 means 100 clocks per unit, 300 cycles
// (RULE10) host adds async time to cycle count times clock period
// (RULE11) transfer rate byte 0x2A, 20 Mbit/s, bit 7 zero
// (RULE12) command class mask reads 0x007, classes 0, 1 and 2
// (RULE13) read block length code reads 0xB, 2048 bytes; codes 12-15 reserved
// (RULE14) partial read flag is 1; block reads down to one byte accepted
// (RULE15) misaligned read flag is 1; reads may cross physical blocks
// (RULE16) driver stage flag is 0; no driver register, its command refused
// (RULE17) capacity is (size+1) times 2^(mult+2) times block length; size 7, mult 7
// (RULE18) permanent and temporary lock flags read 1; writes and erases refused
// (RULE19) bits 7:1 hold CRC7 over bits 127:8 with x^7+x^3+1
// (RULE20) error-correction type reads 0
// (RULE21) record sent most significant bit first, one bit per clock
`timescale 1ns/1ps
module ccr_regs
  import ccr_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire logic        resetn,
  input  wire logic        cmd_valid,
  input  wire logic [5:0]  cmd_index,
  input  wire logic [31:0] cmd_arg,
  output ccr_pkg::ccr_state_t card_state_r,
  output logic             cmd_accept_r,
  output logic             cmd_refused_r,
  output logic             addr_match_r,
  output logic [11:0]      block_len_r,
  output logic             csd_bit_r,
  output logic             csd_valid_r
);
  import ccr_pkg::*;

  // ---------------- address and card state ----------------
  logic [RCA_W-1:0] rca_r;
  logic [RCA_W-1:0] rca_nxt;
  ccr_state_t       state_nxt;
  logic             accept_nxt;
  logic             refused_nxt;
  logic             match_nxt;
  logic [11:0]      blen_r;
  logic [11:0]      blen_nxt;
  logic             start_send;
  logic             sending_r;
  logic             sending_nxt;

  logic [RCA_W-1:0] arg_rca;
  logic             arg_hits;
  logic             is_lock_cmd;
  logic [31:0]      arg_len;

  always_comb begin
    arg_rca     = cmd_arg[ARG_RCA_LSB +: RCA_W];
    arg_hits    = (arg_rca == rca_r); // RULE3
    // every write and erase index falls in this range; the card refuses them all
    is_lock_cmd = (cmd_index >= CMD_WRITE_FIRST) && (cmd_index <= CMD_WRITE_LAST); // RULE18
    arg_len     = cmd_arg;
  end

  always_comb begin
    rca_nxt     = rca_r;
    state_nxt   = card_state_r;
    accept_nxt  = 1'b0;
    refused_nxt = 1'b0;
    match_nxt   = addr_match_r;
    blen_nxt    = blen_r;
    start_send  = 1'b0;
    if (cmd_valid) begin
      match_nxt = arg_hits;
      case (cmd_index)
        CMD_GO_IDLE: begin
          // a fresh identification cycle starts from the default address
          rca_nxt    = RCA_DEFAULT; // RULE1
          state_nxt  = CCR_IDLE;
          accept_nxt = 1'b1;
        end
        CMD_SEND_OP: begin
          if (card_state_r == CCR_IDLE) begin
            state_nxt  = CCR_READY;
            accept_nxt = 1'b1;
          end else begin
            refused_nxt = 1'b1;
          end
        end
        CMD_ALL_SEND_ID: begin
          if (card_state_r == CCR_READY) begin
            state_nxt  = CCR_IDENT;
            accept_nxt = 1'b1;
          end else begin
            refused_nxt = 1'b1;
          end
        end
        CMD_SET_ADDR: begin
          // the reserved address is never taken; the card keeps its current one
          if (card_state_r == CCR_IDENT && arg_rca != RCA_RESERVED) begin // RULE2
            rca_nxt    = arg_rca; // RULE3
            state_nxt  = CCR_STBY;
            accept_nxt = 1'b1;
          end else begin
            refused_nxt = 1'b1;
          end
        end
        CMD_SELECT: begin
          if (arg_rca == RCA_RESERVED) begin
            // deselect broadcast: every selected card drops to standby
            if (card_state_r == CCR_TRAN) begin // RULE2
              state_nxt = CCR_STBY;
            end
            accept_nxt = 1'b1;
          end else if (card_state_r == CCR_STBY && arg_hits) begin // RULE3
            state_nxt  = CCR_TRAN;
            accept_nxt = 1'b1;
          end else if (card_state_r == CCR_TRAN && !arg_hits) begin
            // another card was selected, so this one steps back
            state_nxt = CCR_STBY;
          end
        end
        CMD_SEND_RECORD: begin
          if (card_state_r == CCR_STBY && arg_hits && !sending_r) begin // RULE3
            start_send = 1'b1;
            accept_nxt = 1'b1;
          end else if (arg_hits) begin
            refused_nxt = 1'b1;
          end
        end
        CMD_SET_BLKLEN: begin
          // shorter blocks down to one byte are accepted as partial reads
          if (card_state_r == CCR_TRAN &&
              arg_len >= 32'(BLKLEN_MIN) && arg_len <= 32'(BLKLEN_MAX)) begin // RULE14
            blen_nxt   = arg_len[11:0];
            accept_nxt = 1'b1;
          end else begin
            refused_nxt = 1'b1;
          end
        end
        CMD_SET_DRIVER: begin
          refused_nxt = 1'b1; // RULE16
        end
        default: begin
          refused_nxt = is_lock_cmd; // RULE18
        end
      endcase
    end
  end

  // power-up reset is the only way back to the default besides idle
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      rca_r         <= RCA_DEFAULT; // RULE4
      card_state_r  <= CCR_IDLE;
      cmd_accept_r  <= 1'b0;
      cmd_refused_r <= 1'b0;
      addr_match_r  <= 1'b0;
      blen_r        <= BLKLEN_MAX;
    end else begin
      rca_r         <= rca_nxt;
      card_state_r  <= state_nxt;
      cmd_accept_r  <= accept_nxt;
      cmd_refused_r <= refused_nxt;
      addr_match_r  <= match_nxt;
      blen_r        <= blen_nxt;
    end
  end

  // reads that cross physical block boundaries need no check here
  always_comb begin
    block_len_r = blen_r; // RULE15
  end

  // ---------------- record shift-out ----------------
  logic [6:0] idx_r;
  logic [6:0] idx_nxt;
  logic       valid_nxt;
  logic       rom_bit;

  always_comb begin
    sending_nxt = sending_r;
    idx_nxt     = idx_r;
    if (start_send) begin
      sending_nxt = 1'b1;
      idx_nxt     = 7'(CSD_W - 1); // RULE21
    end else if (sending_r) begin
      if (idx_r == 7'h00) begin
        sending_nxt = 1'b0;
      end else begin
        idx_nxt = idx_r - 7'h01; // RULE21
      end
    end
    // rom read data lag the index by one clock, so valid lags too
    valid_nxt = sending_r;
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      sending_r   <= 1'b0;
      idx_r       <= 7'h00;
      csd_valid_r <= 1'b0;
    end else begin
      sending_r   <= sending_nxt;
      idx_r       <= idx_nxt;
      csd_valid_r <= valid_nxt;
    end
  end

  // record content fixed in the package: RULE5 through RULE20 except RULE10 live there
  ccr_csd_rom u_rom (
    .ref_clk (ref_clk),
    .resetn  (resetn),
    .bit_idx (idx_r),
    .bit_r   (rom_bit)
  );

  always_comb begin
    csd_bit_r = rom_bit; // RULE5
  end

endmodule : ccr_regs

// ---- inc/ccr_pkg.sv ----
// constants of the card address and card specific data register bank
// assumes a command decoder outside that delivers whole, checked command frames
package ccr_pkg;

  // relative card address
  localparam int          RCA_W        = 16;
  localparam logic [15:0] RCA_DEFAULT  = 16'h0001;
  localparam logic [15:0] RCA_RESERVED = 16'h0000;
  localparam int          ARG_RCA_LSB  = 16;

  // command indices
  localparam logic [5:0] CMD_GO_IDLE     = 6'h00;
  localparam logic [5:0] CMD_SEND_OP     = 6'h01;
  localparam logic [5:0] CMD_ALL_SEND_ID = 6'h02;
  localparam logic [5:0] CMD_SET_ADDR    = 6'h03;
  localparam logic [5:0] CMD_SET_DRIVER  = 6'h04;
  localparam logic [5:0] CMD_SELECT      = 6'h07;
  localparam logic [5:0] CMD_SEND_RECORD = 6'h09;
  localparam logic [5:0] CMD_SET_BLKLEN  = 6'h10;
  localparam logic [5:0] CMD_WRITE_FIRST = 6'h18;
  localparam logic [5:0] CMD_WRITE_LAST  = 6'h26;

  // record layout
  localparam int CSD_W        = 128;
  localparam int STRUCT_LSB   = 126;
  localparam int PROTO_LSB    = 122;
  localparam int ASYNC_ACCESS_TIME_LSB     = 112;
  localparam int CLOCKED_ACCESS_CYCLES_LSB     = 104;
  localparam int SPEED_LSB    = 96;
  localparam int CLASS_LSB    = 84;
  localparam int BLKLEN_LSB   = 80;
  localparam int PARTIAL_BIT  = 79;
  localparam int MISALIGN_BIT = 77;
  localparam int DRIVER_BIT   = 76;
  localparam int SIZE_LSB     = 62;
  localparam int RCUR_MIN_LSB = 59;
  localparam int RCUR_MAX_LSB = 56;
  localparam int SMULT_LSB    = 47;
  localparam int FFGRP_BIT    = 15;
  localparam int PERM_BIT     = 13;
  localparam int TEMP_BIT     = 12;
  localparam int FFMT_LSB     = 10;
  localparam int ECC_LSB      = 8;
  localparam int CRC_LSB      = 1;
  localparam int CRC_FIRST    = 127;
  localparam int CRC_LAST     = 8;

  // record field values
  localparam logic [1:0]  RECORD_STRUCTURE_VERSION = 2'h1;
  localparam logic [3:0]  PROTOCOL_VERSION         = 4'h2;
  localparam logic [7:0]  ASYNC_ACCESS_TIME        = 8'h08;
  localparam logic [7:0]  CLOCKED_ACCESS_CYCLES    = 8'h03;
  localparam logic [7:0]  MAX_TRANSFER_RATE        = 8'h2A;
  localparam logic [11:0] COMMAND_CLASS_MASK       = 12'h007;
  localparam logic [3:0]  READ_BLOCK_LENGTH_CODE   = 4'hB;
  localparam logic        PARTIAL_READ_ALLOWED     = 1'h1;
  localparam logic        MISALIGNED_READ_ALLOWED  = 1'h1;
  localparam logic        DRIVER_STAGE_PRESENT     = 1'h0;
  localparam logic [11:0] CAPACITY_SIZE            = 12'h007;
  localparam logic [2:0]  READ_CURRENT_MIN         = 3'h4;
  localparam logic [2:0]  READ_CURRENT_MAX         = 3'h4;
  localparam logic [2:0]  CAPACITY_MULTIPLIER      = 3'h7;
  localparam logic        FILE_FORMAT_GROUP        = 1'h0;
  localparam logic        PERMANENT_LOCK_FLAG      = 1'h1;
  localparam logic        TEMPORARY_LOCK_FLAG      = 1'h1;
  localparam logic [1:0]  FILE_FORMAT_CODE         = 2'h0;
  localparam logic [1:0]  ECC_TYPE                 = 2'h0;
  localparam logic        RECORD_STOP_BIT          = 1'h1;
  localparam logic [6:0]  CRC7_POLY                = 7'h09;

  // block length limits for the length command
  localparam logic [11:0] BLKLEN_MIN = 12'h001;
  localparam logic [11:0] BLKLEN_MAX = 12'h800;

  typedef enum logic [2:0] {
    CCR_IDLE,
    CCR_READY,
    CCR_IDENT,
    CCR_STBY,
    CCR_TRAN
  } ccr_state_t;

  function automatic logic [6:0] ccr_crc7(input logic [CSD_W-1:0] rec);
    logic [6:0] crc;
    logic       fb;
    crc = 7'h00;
    for (int i = CRC_FIRST; i >= CRC_LAST; i--) begin
      fb  = rec[i] ^ crc[6];
      crc = {crc[5:0], 1'b0};
      if (fb) begin
        crc = crc ^ CRC7_POLY;
      end
    end
    return crc;
  endfunction : ccr_crc7

  function automatic logic [CSD_W-1:0] ccr_record();
    logic [CSD_W-1:0] r;
    r = '0; // RULE5
    r[STRUCT_LSB +: 2]   = RECORD_STRUCTURE_VERSION; // RULE6
    r[PROTO_LSB +: 4]    = PROTOCOL_VERSION; // RULE7
    r[ASYNC_ACCESS_TIME_LSB +: 8]     = ASYNC_ACCESS_TIME; // RULE8
    r[CLOCKED_ACCESS_CYCLES_LSB +: 8]     = CLOCKED_ACCESS_CYCLES; // RULE9
    r[SPEED_LSB +: 8]    = MAX_TRANSFER_RATE; // RULE11
    r[CLASS_LSB +: 12]   = COMMAND_CLASS_MASK; // RULE12
    r[BLKLEN_LSB +: 4]   = READ_BLOCK_LENGTH_CODE; // RULE13
    r[PARTIAL_BIT]       = PARTIAL_READ_ALLOWED; // RULE14
    r[MISALIGN_BIT]      = MISALIGNED_READ_ALLOWED; // RULE15
    r[DRIVER_BIT]        = DRIVER_STAGE_PRESENT; // RULE16
    r[SIZE_LSB +: 12]    = CAPACITY_SIZE; // RULE17
    r[RCUR_MIN_LSB +: 3] = READ_CURRENT_MIN;
    r[RCUR_MAX_LSB +: 3] = READ_CURRENT_MAX;
    r[SMULT_LSB +: 3]    = CAPACITY_MULTIPLIER; // RULE17
    r[FFGRP_BIT]         = FILE_FORMAT_GROUP;
    r[PERM_BIT]          = PERMANENT_LOCK_FLAG; // RULE18
    r[TEMP_BIT]          = TEMPORARY_LOCK_FLAG; // RULE18
    r[FFMT_LSB +: 2]     = FILE_FORMAT_CODE;
    r[ECC_LSB +: 2]      = ECC_TYPE; // RULE20
    r[CRC_LSB +: 7]      = ccr_crc7(r); // RULE19
    r[0]                 = RECORD_STOP_BIT;
    return r;
  endfunction : ccr_record

endpackage : ccr_pkg

// ---- logic/ccr_csd_rom.sv ----
// fixed card specific data record, one bit read per clock by index
// assumes the index is driven synchronously to ref_clk
`timescale 1ns/1ps
module ccr_csd_rom
  import ccr_pkg::*;
(
  input  wire logic       ref_clk,
  input  wire logic       resetn,
  input  wire logic [6:0] bit_idx,
  output logic            bit_r
);

  // the record is a constant, so no write path exists at all
  localparam logic [CSD_W-1:0] RECORD = ccr_record();

  logic bit_nxt;

  always_comb begin
    bit_nxt = RECORD[bit_idx];
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      bit_r <= 1'b0;
    end else begin
      bit_r <= bit_nxt;
    end
  end

endmodule : ccr_csd_rom

// ---- sim/ccr_regs_checker.sv ----
// port assertions for the card address and record register bank
// assumes one ref_clk domain and the bind at the foot of this file
`timescale 1ns/1ps
module ccr_regs_checker
  import ccr_pkg::*;
(
  input wire logic                ref_clk,
  input wire logic                resetn,
  input wire logic                cmd_valid,
  input wire logic [5:0]          cmd_index,
  input wire logic [31:0]         cmd_arg,
  input wire ccr_pkg::ccr_state_t card_state_r,
  input wire logic                cmd_accept_r,
  input wire logic                cmd_refused_r,
  input wire logic                addr_match_r,
  input wire logic [11:0]         block_len_r,
  input wire logic                csd_bit_r,
  input wire logic                csd_valid_r
);
  logic [7:0] run_r;
  logic [7:0] run_nxt;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  always_comb begin
    run_nxt = csd_valid_r ? run_r + 8'h01 : 8'h00;
  end
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      run_r <= 8'h00;
    end else begin
      run_r <= run_nxt;
    end
  end
  sequence s_rec_go;
    cmd_valid && cmd_index == CMD_SEND_RECORD ##1 cmd_accept_r;
  endsequence
  chk_answer_cause: assert property ((cmd_accept_r || cmd_refused_r) |->
    $past(cmd_valid) && !(cmd_accept_r && cmd_refused_r)) else $error("answer without a command");
  chk_rec_start: assert property (s_rec_go |=> csd_valid_r && !csd_bit_r)
    else $error("record did not start with bit 127");
  chk_rec_length: assert property ($fell(csd_valid_r) |-> run_r == 8'h80)
    else $error("record length is not 128");
  chk_rec_bound: assert property (csd_valid_r |-> run_r < 8'h80)
    else $error("record runs past 128 bits");
  chk_driver_refused: assert property (cmd_valid && cmd_index == CMD_SET_DRIVER |=> cmd_refused_r)
    else $error("driver command not refused");
  chk_write_refused: assert property (cmd_valid && cmd_index inside {[CMD_WRITE_FIRST:CMD_WRITE_LAST]}
    |=> cmd_refused_r && !cmd_accept_r) else $error("write or erase not refused");
  chk_zero_addr: assert property (cmd_valid && cmd_index == CMD_SET_ADDR && cmd_arg[31:16] == RCA_RESERVED
    |=> cmd_refused_r && $stable(card_state_r)) else $error("address zero assigned");
  chk_deselect_all: assert property (cmd_valid && cmd_index == CMD_SELECT && cmd_arg[31:16] == 16'h0000
    && card_state_r == CCR_TRAN |=> card_state_r == CCR_STBY) else $error("select zero kept transfer");
  chk_reset_default: assert property ($rose(resetn) |-> card_state_r == CCR_IDLE && block_len_r == 12'h800)
    else $error("state after power-up reset");
endmodule : ccr_regs_checker

bind ccr_regs ccr_regs_checker u_chk (.ref_clk(ref_clk), .resetn(resetn), .cmd_valid(cmd_valid),
  .cmd_index(cmd_index), .cmd_arg(cmd_arg), .card_state_r(card_state_r), .cmd_accept_r(cmd_accept_r),
  .cmd_refused_r(cmd_refused_r), .addr_match_r(addr_match_r), .block_len_r(block_len_r),
  .csd_bit_r(csd_bit_r), .csd_valid_r(csd_valid_r));

// ---- sim/ccr_host_model.sv ----
// behavioural host controller issuing checked command frames
// assumes the card takes a frame on the rising edge of ref_clk
`timescale 1ns/1ps
module ccr_host_model (
  input  wire logic ref_clk,
  output logic      cmd_valid,
  output logic [5:0]  cmd_index,
  output logic [31:0] cmd_arg
);
  initial begin
    cmd_valid = 1'b0;
    cmd_index = 6'h3F;
    cmd_arg   = 32'hA5A5_5A5A;
  end
  // idle lines carry inverted junk so a stale frame is never mistaken for a fresh one
  task issue(input logic [5:0] idx, input logic [31:0] arg, input int gap);
    repeat (gap) @(negedge ref_clk);
    @(negedge ref_clk);
    cmd_valid = 1'b1;
    cmd_index = idx;
    cmd_arg   = arg;
    @(negedge ref_clk);
    cmd_valid = 1'b0;
    cmd_index = ~idx;
    cmd_arg   = ~arg;
  endtask : issue
endmodule : ccr_host_model

// ---- sim/tb_ccr_regs.sv ----
// self-checking bench for the card address and record register bank
// assumes a 50 MHz ref_clk and the host model for command frames
`timescale 1ns/1ps
module tb_ccr_regs;
  import ccr_pkg::*;
  logic               ref_clk = 1'b0;
  logic               resetn = 1'b0;
  logic               cmd_valid;
  logic [5:0]         cmd_index;
  logic [31:0]        cmd_arg;
  ccr_state_t         card_state_r;
  logic               cmd_accept_r;
  logic               cmd_refused_r;
  logic               addr_match_r;
  logic [11:0]        block_len_r;
  logic               csd_bit_r;
  logic               csd_valid_r;
  int                 n_mismatch = 0;
  int                 checks_done = 0;
  int                 cycles = 0;
  logic [119:0]       head;
  logic [6:0]         crc;
  logic [127:0]       rec;
  logic [127:0]       got;
  always #10 ref_clk = ~ref_clk;
  ccr_host_model host (.ref_clk(ref_clk), .cmd_valid(cmd_valid), .cmd_index(cmd_index), .cmd_arg(cmd_arg));
  ccr_regs DUT (.ref_clk(ref_clk), .resetn(resetn), .cmd_valid(cmd_valid), .cmd_index(cmd_index),
    .cmd_arg(cmd_arg), .card_state_r(card_state_r), .cmd_accept_r(cmd_accept_r), .cmd_refused_r(cmd_refused_r),
    .addr_match_r(addr_match_r), .block_len_r(block_len_r), .csd_bit_r(csd_bit_r), .csd_valid_r(csd_valid_r));
  task results();
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : results
  task chk(input string what, input logic [127:0] exp, input logic [127:0] seen);
    checks_done++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch %s expected %0h seen %0h", what, exp, seen);
    end
  endtask : chk
  task cmd(input logic [5:0] i, input logic [31:0] a, input logic acc, input logic rfs);
    host.issue(i, a, int'(i[1:0]));
    chk("accept", 128'(acc), 128'(cmd_accept_r));
    chk("refused", 128'(rfs), 128'(cmd_refused_r));
  endtask : cmd
  task do_reset();
    resetn = 1'b0;
    repeat (4) @(negedge ref_clk);
    resetn = 1'b1;
  endtask : do_reset
  // a matched record request outside standby is refused, an unmatched one is silent
  // the length command survives the idle command; only power-up reset restores 2048
  task probe_default(input logic [11:0] exp_len);
    chk("state", 128'(CCR_IDLE), 128'(card_state_r));
    chk("blklen", 128'(exp_len), 128'(block_len_r));
    cmd(CMD_SEND_RECORD, 32'h0001_0000, 1'b0, 1'b1);
    chk("match", 128'h1, 128'(addr_match_r));
  endtask : probe_default
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 5000) begin
      n_mismatch++;
      results();
    end
  end
  initial begin
    head = {2'h1, 4'h2, 2'h0, 8'h08, 8'h03, 8'h2A, 12'h007, 4'hB, 4'hA, 2'h0, 12'h007, 3'h4, 3'h4, 6'h0, 3'h7,
            31'h0, 8'h30};
    crc = 7'h00;
    for (int i = 119; i >= 0; i--) begin
      crc = {crc[5:0], 1'b0} ^ ((head[i] ^ crc[6]) ? 7'h09 : 7'h00);
    end
    rec = {head, crc, 1'b1};
    do_reset();
    probe_default(12'h800);
    cmd(CMD_SET_ADDR, 32'h1234_0000, 1'b0, 1'b1);
    cmd(CMD_SEND_OP, 32'h0, 1'b1, 1'b0);
    cmd(CMD_ALL_SEND_ID, 32'h0, 1'b1, 1'b0);
    cmd(CMD_SET_ADDR, 32'h0000_0000, 1'b0, 1'b1);
    cmd(CMD_SET_ADDR, 32'h1234_0000, 1'b1, 1'b0);
    chk("state", 128'(CCR_STBY), 128'(card_state_r));
    cmd(CMD_SEND_RECORD, 32'h0001_0000, 1'b0, 1'b0);
    chk("match", 128'h0, 128'(addr_match_r));
    cmd(CMD_SEND_RECORD, 32'h1234_0000, 1'b1, 1'b0);
    @(negedge ref_clk);
    for (int k = 127; k >= 0; k--) begin
      got[k] = (csd_valid_r === 1'b1) ? csd_bit_r : 1'bx;
      @(negedge ref_clk);
    end
    chk("valid end", 128'h0, 128'(csd_valid_r));
    chk("record", rec, got);
    chk("capacity", 128'(32'h0080_0000), 128'((got[73:62] + 1) * (1 << (got[49:47] + 2)) * (1 << got[83:80])));
    chk("access ns", 128'(6001), 128'(1 + 100 * got[111:104] * 20));
    cmd(CMD_SET_DRIVER, 32'h0, 1'b0, 1'b1);
    cmd(CMD_SELECT, 32'h1234_0000, 1'b1, 1'b0);
    chk("state", 128'(CCR_TRAN), 128'(card_state_r));
    cmd(CMD_SET_BLKLEN, 32'h0000_0001, 1'b1, 1'b0);
    chk("blklen", 128'h1, 128'(block_len_r));
    cmd(CMD_SET_BLKLEN, 32'h0000_0801, 1'b0, 1'b1);
    for (int c = 24; c <= 38; c++) begin
      cmd(6'(c), 32'h1234_0000, 1'b0, 1'b1);
    end
    host.issue(CMD_SELECT, 32'h0000_0000, 0);
    chk("state", 128'(CCR_STBY), 128'(card_state_r));
    host.issue(CMD_GO_IDLE, 32'h0, 0);
    probe_default(12'h001);
    cmd(CMD_SEND_OP, 32'h0, 1'b1, 1'b0);
    cmd(CMD_ALL_SEND_ID, 32'h0, 1'b1, 1'b0);
    cmd(CMD_SET_ADDR, 32'h1234_0000, 1'b1, 1'b0);
    // a power-up reset with an assigned address must bring back the default one
    do_reset();
    probe_default(12'h800);
    results();
  end
endmodule : tb_ccr_regs
